/* hw/ncs_pkg.sv */
package ncs_pkg;
    // Device register offsets, one whole register of up to 32 bits per address on the device port
    localparam logic [9:0] NCS_OFS_RDIV = 10'h217;
    localparam logic [9:0] NCS_OFS_SYNC = 10'h219;
    localparam logic [9:0] NCS_OFS_FREQ_BASE = 10'h220;
    localparam logic [9:0] NCS_OFS_PHASE_BASE = 10'h224;
    localparam logic [9:0] NCS_OFS_FREQB_BASE = 10'h260;
    localparam logic [9:0] NCS_OFS_CSEL = 10'h215;
    localparam logic [9:0] NCS_OFS_PRESET_SELECT_MODE = 10'h214;
    localparam logic [9:0] NCS_PRESET_STRIDE = 10'h008;
    // Reset values
    localparam logic [31:0] NCS_FREQ_RST = 32'hC0000000;
    localparam logic [15:0] NCS_RDIV_RST = 16'h0000;
    localparam logic [7:0] NCS_SYNC_RST = 8'h02;
    localparam logic [15:0] NCS_PHASE_RST = 16'h0000;
    // Field positions in the sync control register
    localparam int NCS_BIT_ARM = 0;
    localparam int NCS_BIT_LINK = 1;
    // Preset count and advisory divisor limit
    localparam int NCS_PRESETS = 4;
    localparam logic [15:0] NCS_RDIV_ADVISED_MAX = 16'h2000;
    // Controller register byte addresses on AHB-Lite
    localparam logic [7:0] NCS_AHB_CMD = 8'h00;
    localparam logic [7:0] NCS_AHB_WDATA = 8'h04;
    localparam logic [7:0] NCS_AHB_RDATA = 8'h08;
    localparam logic [7:0] NCS_AHB_STATUS = 8'h0C;
    // Command word fields: [9:0] device offset, [16] write, [17] go
    localparam int NCS_CMD_WR = 16;
    localparam int NCS_CMD_GO = 17;
    localparam int NCS_ST_BUSY = 0;
    localparam int NCS_ST_WARN = 1;
    // AHB encodings
    localparam logic [1:0] NCS_HTRANS_IDLE = 2'h0;
    localparam logic [1:0] NCS_HTRANS_NONSEQ = 2'h2;
    // Phase word sits at the top of the 32-bit accumulator
    localparam int NCS_PHASE_SHIFT = 16;
endpackage : ncs_pkg

/* hw/ncs_if.sv */
`timescale 1ns/1ps
// Register port and sync pins between controller and converter
interface ncs_if;
    logic reg_req; // Register access strobe
    logic reg_wr; // Write when high
    logic [9:0] reg_addr; // Device offset
    logic [31:0] reg_wdata; // Write data
    logic [31:0] reg_rdata; // Read data, valid cycle after strobe
    logic sync_n; // Link sync pin, rising edge starts link
    logic frame_boundary; // Multiframe or extended multiblock boundary pulse
    logic sysref; // SYSREF level
    modport dev (input reg_req, input reg_wr, input reg_addr, input reg_wdata, output reg_rdata,
                 input sync_n, input frame_boundary, input sysref);
    modport ctl (output reg_req, output reg_wr, output reg_addr, output reg_wdata, input reg_rdata);
endinterface : ncs_if

/* hw/ncs_device.sv */
`timescale 1ns/1ps
module ncs_device
    import ncs_pkg::*;
(
    input wire logic hclk, // Sample clock
    input wire logic hresetn, // Async reset, active low
    ncs_if.dev link, // Register port and sync pins
    output logic [31:0] phase_a, // Channel A oscillator phase
    output logic [31:0] phase_b, // Channel B oscillator phase
    output logic armed, // Sysref init armed
    output logic phase_init // Pulse when phases were initialised
);
    import ncs_pkg::*;

    // All state of the device
    typedef struct packed {
        logic [NCS_PRESETS-1:0][31:0] freq_a; // Channel A words
        logic [NCS_PRESETS-1:0][31:0] freq_b; // Channel B words
        logic [NCS_PRESETS-1:0][15:0] phs_a; // Channel A phase words
        logic [NCS_PRESETS-1:0][15:0] phs_b; // Channel B phase words
        logic [15:0] rdiv; // Shared divisor
        logic [7:0] sync; // Sync control
        logic [7:0] csel; // Preset select
        logic [7:0] preset_select_mode; // Preset select mode
        logic arm_zero_seen; // A zero was written to arm bit
        logic armed; // Waiting for sysref edge
        logic pend_link; // Sync rose, wait for boundary
        logic sync_d; // Delayed sync pin
        logic sysref_d; // Delayed sysref
        logic [31:0] acc_a; // Accumulator A
        logic [31:0] acc_b; // Accumulator B
        logic [15:0] sub_a; // Divisor sub-count A
        logic [15:0] sub_b; // Divisor sub-count B
        logic [31:0] rdata; // Read data
        logic init; // Init pulse
    } ncs_dev_t;

    ncs_dev_t st_reg;
    ncs_dev_t st_next;

    // Step the accumulator; with a divisor the word is in steps of fs/rdiv/2^32,
    // carried by a sub-count that wraps at rdiv (range is 2^32 * rdiv)
    function automatic logic [47:0] ncs_step(input logic [31:0] acc, input logic [15:0] sub,
                                             input logic [31:0] f, input logic [15:0] rdiv);
        logic [47:0] r;
        logic [15:0] s;
        r = '0;
        s = '0;
        if (rdiv == NCS_RDIV_RST) begin
            r = {16'h0000, acc + f};
        end else begin
            // Fractional part counts in 1/rdiv units of one full word step
            s = sub + 16'h0001;
            if (s >= rdiv) begin
                s = 16'h0000;
                r = {s, acc + f};
            end else begin
                r = {s, acc};
            end
        end
        return r;
    endfunction : ncs_step

    // Preset index for a channel given the select mode
    function automatic logic [1:0] ncs_sel(input logic [7:0] preset_select_mode, input logic [1:0] csel);
        return (preset_select_mode[1:0] == 2'h0) ? csel : 2'h0;
    endfunction : ncs_sel

    // Next state
    always_comb begin
        logic [47:0] sa;
        logic [47:0] sb;
        logic [1:0] pa;
        logic [1:0] pb;
        logic link_go;
        logic sref_go;
        logic [9:0] rel;
        st_next = st_reg;
        sa = '0;
        sb = '0;
        link_go = 1'b0;
        sref_go = 1'b0;
        rel = '0;
        pa = '0;
        pb = '0;
        st_next.init = 1'b0;
        st_next.sync_d = link.sync_n;
        st_next.sysref_d = link.sysref;
        pa = ncs_sel(st_reg.preset_select_mode, st_reg.csel[1:0]);
        pb = ncs_sel(st_reg.preset_select_mode, st_reg.csel[3:2]);
        // Accumulate every sample clock, or once per rdiv clocks with a divisor
        sa = ncs_step(st_reg.acc_a, st_reg.sub_a, st_reg.freq_a[pa], st_reg.rdiv);
        sb = ncs_step(st_reg.acc_b, st_reg.sub_b, st_reg.freq_b[pb], st_reg.rdiv);
        st_next.acc_a = sa[31:0];
        st_next.sub_a = sa[47:32];
        st_next.acc_b = sb[31:0];
        st_next.sub_b = sb[47:32];
        // Link start: sync rise then first boundary; 8b/10b and 64b/66b alike
        if (st_reg.pend_link && link.frame_boundary) begin
            link_go = 1'b1;
            st_next.pend_link = 1'b0;
        end
        // A rise in the same cycle as a boundary stays pending for the next boundary
        if (st_reg.sync[NCS_BIT_LINK] && link.sync_n && !st_reg.sync_d) begin
            st_next.pend_link = 1'b1;
        end
        if (!st_reg.sync[NCS_BIT_LINK]) begin
            st_next.pend_link = 1'b0;
        end
        // Sysref edge used once, then disarm
        if (st_reg.armed && link.sysref && !st_reg.sysref_d) begin
            sref_go = 1'b1;
            st_next.armed = 1'b0;
        end
        // Initialise both phases
        if (link_go || sref_go) begin
            st_next.acc_a = 32'h00000000;
            st_next.acc_b = 32'h00000000;
            st_next.sub_a = 16'h0000;
            st_next.sub_b = 16'h0000;
            st_next.init = 1'b1;
        end
        // Register port
        if (link.reg_req) begin
            if (link.reg_addr == NCS_OFS_RDIV) begin
                if (link.reg_wr) st_next.rdiv = link.reg_wdata[15:0];
                st_next.rdata = {16'h0000, st_reg.rdiv};
            end else if (link.reg_addr == NCS_OFS_SYNC) begin
                if (link.reg_wr) begin
                    st_next.sync = link.reg_wdata[7:0];
                    if (!link.reg_wdata[NCS_BIT_ARM]) begin
                        st_next.arm_zero_seen = 1'b1;
                    end else if (st_reg.arm_zero_seen) begin
                        st_next.armed = 1'b1;
                        st_next.arm_zero_seen = 1'b0;
                    end
                end
                st_next.rdata = {24'h000000, st_reg.sync};
            end else if (link.reg_addr == NCS_OFS_CSEL) begin
                if (link.reg_wr) st_next.csel = link.reg_wdata[7:0];
                st_next.rdata = {24'h000000, st_reg.csel};
            end else if (link.reg_addr == NCS_OFS_PRESET_SELECT_MODE) begin
                if (link.reg_wr) st_next.preset_select_mode = link.reg_wdata[7:0];
                st_next.rdata = {24'h000000, st_reg.preset_select_mode};
            end else begin
                st_next.rdata = 32'h00000000;
                for (int i = 0; i < NCS_PRESETS; i++) begin
                    if (link.reg_addr == NCS_OFS_FREQ_BASE + 10'(i) * NCS_PRESET_STRIDE) begin
                        if (link.reg_wr) st_next.freq_a[i] = link.reg_wdata;
                        st_next.rdata = st_reg.freq_a[i];
                    end
                    if (link.reg_addr == NCS_OFS_PHASE_BASE + 10'(i) * NCS_PRESET_STRIDE) begin
                        if (link.reg_wr) st_next.phs_a[i] = link.reg_wdata[15:0];
                        st_next.rdata = {16'h0000, st_reg.phs_a[i]};
                    end
                    if (link.reg_addr == NCS_OFS_FREQB_BASE + 10'(i) * NCS_PRESET_STRIDE) begin
                        if (link.reg_wr) st_next.freq_b[i] = link.reg_wdata;
                        st_next.rdata = st_reg.freq_b[i];
                    end
                    // Channel B phase words sit as far above its words as on channel A
                    rel = NCS_OFS_FREQB_BASE + (NCS_OFS_PHASE_BASE - NCS_OFS_FREQ_BASE);
                    if (link.reg_addr == rel + 10'(i) * NCS_PRESET_STRIDE) begin
                        if (link.reg_wr) st_next.phs_b[i] = link.reg_wdata[15:0];
                        st_next.rdata = {16'h0000, st_reg.phs_b[i]};
                    end
                end
            end
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= '0;
            for (int i = 0; i < NCS_PRESETS; i++) begin
                st_reg.freq_a[i] <= NCS_FREQ_RST;
                st_reg.freq_b[i] <= NCS_FREQ_RST;
            end
            st_reg.rdiv <= NCS_RDIV_RST;
            st_reg.sync <= NCS_SYNC_RST;
            st_reg.sync_d <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Phase offset left-justified onto accumulator
    assign phase_a = st_reg.acc_a + {st_reg.phs_a[ncs_sel(st_reg.preset_select_mode, st_reg.csel[1:0])], 16'h0000};
    assign phase_b = st_reg.acc_b + {st_reg.phs_b[ncs_sel(st_reg.preset_select_mode, st_reg.csel[3:2])], 16'h0000};
    assign armed = st_reg.armed;
    assign phase_init = st_reg.init;
    assign link.reg_rdata = st_reg.rdata;
endmodule : ncs_device

/* hw/ncs_ctl.sv */
`timescale 1ns/1ps
// AHB-Lite slave that relays register accesses to the device port
module ncs_ctl
    import ncs_pkg::*;
(
    input wire logic hclk, // Clock
    input wire logic hresetn, // Async reset, active low
    input wire logic hsel, // Slave select
    input wire logic [7:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write
    input wire logic [2:0] hsize, // Size, word only
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Always ready
    output logic hresp, // Always OKAY
    ncs_if.ctl link // Device register port
);
    import ncs_pkg::*;

    // Controller state
    typedef enum logic [1:0] {NCS_IDLE, NCS_ISSUE, NCS_WAIT} ncs_fsm_t;
    typedef struct packed {
        logic wr_pend; // Data phase of a write pending
        logic [7:0] addr; // Latched address
        logic [31:0] cmd; // Command word
        logic [31:0] wdata; // Device write data
        logic [31:0] rdata; // Device read result
        logic busy; // Access in flight
        logic warn; // Divisor above advised limit
        ncs_fsm_t fsm; // Relay step
        logic [31:0] hrd; // Bus read data
    } ncs_ctl_t;
    ncs_ctl_t st_reg;
    ncs_ctl_t st_next;

    // Next state
    always_comb begin
        st_next = st_reg;
        st_next.wr_pend = 1'b0;
        // Address phase
        if (hsel && hready && htrans == NCS_HTRANS_NONSEQ) begin
            st_next.addr = haddr;
            st_next.wr_pend = hwrite;
            if (!hwrite) begin
                if (haddr == NCS_AHB_CMD) st_next.hrd = st_reg.cmd;
                else if (haddr == NCS_AHB_WDATA) st_next.hrd = st_reg.wdata;
                else if (haddr == NCS_AHB_RDATA) st_next.hrd = st_reg.rdata;
                else if (haddr == NCS_AHB_STATUS) st_next.hrd = {30'h0, st_reg.warn, st_reg.busy};
                else st_next.hrd = 32'h00000000;
            end
        end
        // Data phase of a write
        if (st_reg.wr_pend) begin
            if (st_reg.addr == NCS_AHB_CMD) begin
                st_next.cmd = hwdata;
                if (hwdata[NCS_CMD_GO] && !st_reg.busy) begin
                    st_next.busy = 1'b1;
                    st_next.fsm = NCS_ISSUE;
                end
            end else if (st_reg.addr == NCS_AHB_WDATA) begin
                st_next.wdata = hwdata;
            end
        end
        // Relay: one strobe, then capture read data
        case (st_reg.fsm)
            NCS_ISSUE: begin
                st_next.fsm = NCS_WAIT;
                // Flag divisors above the advised bound
                if (st_reg.cmd[NCS_CMD_WR] && st_reg.cmd[9:0] == NCS_OFS_RDIV) begin
                    st_next.warn = st_reg.wdata[15:0] > NCS_RDIV_ADVISED_MAX;
                end
            end
            NCS_WAIT: begin
                st_next.rdata = link.reg_rdata;
                st_next.busy = 1'b0;
                st_next.fsm = NCS_IDLE;
            end
            default: begin
                // Idle: left alone, so a go write in the data phase above starts the relay
            end
        endcase
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Device strobe; order of writes is software's duty
    assign link.reg_req = st_reg.fsm == NCS_ISSUE;
    assign link.reg_wr = st_reg.cmd[NCS_CMD_WR];
    assign link.reg_addr = st_reg.cmd[9:0];
    assign link.reg_wdata = st_reg.wdata;
    assign hrdata = st_reg.hrd;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
endmodule : ncs_ctl

/* test/ncs_chk.sv */
`timescale 1ns/1ps
// Watches the device register port, the sync pins and channel A
module ncs_chk
    import ncs_pkg::*;
(
    input wire logic hclk, // Clock
    input wire logic hresetn, // Async reset, active low
    input wire logic reg_req, // Register strobe
    input wire logic reg_wr, // Write flag
    input wire logic [9:0] reg_addr, // Device offset
    input wire logic [31:0] reg_wdata, // Write data
    input wire logic [31:0] reg_rdata, // Read data
    input wire logic sync_n, // Link sync pin
    input wire logic frame_boundary, // Boundary pulse
    input wire logic sysref, // SYSREF level
    input wire logic [31:0] phase_a, // Channel A phase
    input wire logic armed, // Arm flag
    input wire logic phase_init // Init pulse
);
    import ncs_pkg::*;
    logic [15:0] div_sh; // Divisor shadow
    logic [31:0] frq_sh; // Preset 0 frequency shadow
    logic link_sh; // Link start bit shadow
    logic zero_seen; // Arm bit last written as 0
    logic pend; // Sync rise waiting for a boundary
    logic sel_ok; // Channel A select field last written as preset 0
    logic [2:0] calm; // Quiet cycles, saturating
    logic arm_wr; // Write of a 1 to the arm bit
    assign arm_wr = reg_req && reg_wr && reg_addr == NCS_OFS_SYNC && reg_wdata[NCS_BIT_ARM];

    // Shadows of what software wrote; the step checks wait for calm so init and writes stay out
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_sh <= NCS_RDIV_RST;
            frq_sh <= NCS_FREQ_RST;
            link_sh <= NCS_SYNC_RST[NCS_BIT_LINK];
            zero_seen <= 1'b0;
            pend <= 1'b0;
            sel_ok <= 1'b1;
            calm <= 3'h0;
        end else begin
            if (reg_req && reg_wr && reg_addr == NCS_OFS_RDIV) div_sh <= reg_wdata[15:0];
            if (reg_req && reg_wr && reg_addr == NCS_OFS_FREQ_BASE) frq_sh <= reg_wdata;
            if (reg_req && reg_wr && reg_addr == NCS_OFS_CSEL) sel_ok <= reg_wdata[1:0] == 2'h0;
            if (reg_req && reg_wr && reg_addr == NCS_OFS_SYNC) begin
                link_sh <= reg_wdata[NCS_BIT_LINK];
                zero_seen <= !reg_wdata[NCS_BIT_ARM];
            end
            // Boundary consumes a pending link start
            if (frame_boundary) pend <= 1'b0;
            else if ($rose(sync_n) && link_sh) pend <= 1'b1;
            if (reg_req || frame_boundary || sysref || phase_init) calm <= 3'h0;
            else if (calm != 3'h7) calm <= calm + 3'h1;
        end
    end

    default clocking dc @(posedge hclk); endclocking
    default disable iff (!hresetn);

    arm_set_a: assert property (arm_wr && zero_seen |=> armed)
        else $error("arm sequence did not arm");
    arm_hold_a: assert property (arm_wr && !zero_seen && !armed |=> !armed)
        else $error("arm without prior zero armed");
    arm_cause_a: assert property ($rose(armed) |-> $past(arm_wr))
        else $error("armed rose without an arm write");
    sysref_fire_a: assert property (armed && $rose(sysref) |-> ##[1:4] (phase_init && !armed))
        else $error("sysref edge did not init and disarm");
    link_init_a: assert property (pend && frame_boundary |-> ##[1:3] phase_init)
        else $error("boundary after sync rise did not init");
    div_read_a: assert property (reg_req && !reg_wr && reg_addr == NCS_OFS_RDIV |=> reg_rdata[15:0] == div_sh)
        else $error("divisor readback wrong");
    freq_read_a: assert property (reg_req && !reg_wr && reg_addr == NCS_OFS_FREQ_BASE |=> reg_rdata == frq_sh)
        else $error("frequency readback wrong");
    acc_step_a: assert property (calm == 3'h7 && sel_ok && div_sh == 16'h0 |-> phase_a - $past(phase_a) == frq_sh)
        else $error("plain accumulator step wrong");
    acc_div_a: assert property (calm == 3'h7 && sel_ok && div_sh != 16'h0 |->
        (phase_a - $past(phase_a) == frq_sh) || (phase_a == $past(phase_a)))
        else $error("divided accumulator step wrong");
endmodule : ncs_chk

/* test/nco_frequency_sync_control_bench.sv */
`timescale 1ns/1ps
// Controller and converter face each other; the bench is the AHB master and the pin source
module nco_frequency_sync_control_bench;
    import ncs_pkg::*;
    typedef struct {logic [9:0] off; logic [31:0] d; logic [31:0] m;} ncs_row_t;
    logic hclk; // Clock
    logic hresetn; // Reset, active low
    logic hsel; // Slave select
    logic [7:0] haddr; // Address
    logic [1:0] htrans; // Transfer type
    logic hwrite; // Write
    logic [31:0] hwdata; // Write data
    logic [31:0] hrdata; // Read data
    logic hreadyout; // Ready, fed back as hready
    logic [31:0] phase_a; // Channel A phase
    logic [31:0] phase_b; // Channel B phase
    logic hresp; // Bus response
    logic armed; // Arm flag
    logic phase_init; // Init pulse
    logic [31:0] rd; // Last read data
    logic [31:0] p0; // Phase snapshot
    int mismatches; // Mismatch count
    int cmp_count; // Compare count
    int cyc; // Cycles run
    // Write then read back: offset, data, mask
    ncs_row_t rows [7] = '{'{NCS_OFS_RDIV, 32'hFFFF1FFF, 32'h0000FFFF}, '{NCS_OFS_FREQ_BASE, 32'h12345678, 32'hFFFFFFFF},
        '{10'h228, 32'h0ABCDEF1, 32'hFFFFFFFF}, '{10'h238, 32'h80000001, 32'hFFFFFFFF},
        '{NCS_OFS_FREQB_BASE, 32'h00000001, 32'hFFFFFFFF}, '{NCS_OFS_PHASE_BASE, 32'h00008001, 32'h0000FFFF},
        '{NCS_OFS_SYNC, 32'h00000002, 32'h000000FF}};
    // Reset values: offset, expected, mask
    ncs_row_t rst [5] = '{'{NCS_OFS_FREQ_BASE, NCS_FREQ_RST, 32'hFFFFFFFF}, '{10'h238, NCS_FREQ_RST, 32'hFFFFFFFF},
        '{NCS_OFS_FREQB_BASE, NCS_FREQ_RST, 32'hFFFFFFFF}, '{NCS_OFS_RDIV, 32'h0, 32'h0000FFFF},
        '{NCS_OFS_SYNC, 32'h2, 32'h000000FF}};

    ncs_if ncs_if_i();
    ncs_ctl ncs_ctl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .link(ncs_if_i));
    ncs_device ncs_device_i (.hclk(hclk), .hresetn(hresetn), .link(ncs_if_i), .phase_a(phase_a), .phase_b(phase_b),
        .armed(armed), .phase_init(phase_init));
    ncs_chk chk_i (.hclk(hclk), .hresetn(hresetn), .reg_req(ncs_if_i.reg_req), .reg_wr(ncs_if_i.reg_wr),
        .reg_addr(ncs_if_i.reg_addr), .reg_wdata(ncs_if_i.reg_wdata), .reg_rdata(ncs_if_i.reg_rdata),
        .sync_n(ncs_if_i.sync_n), .frame_boundary(ncs_if_i.frame_boundary), .sysref(ncs_if_i.sysref),
        .phase_a(phase_a), .armed(armed), .phase_init(phase_init));

    // Clock, 25 ns period
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    task automatic stop_test();
        $display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test

    // Hang guard, far above the few hundred cycles needed
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One AHB transfer, entered just after an edge; read data lands in rd
    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= NCS_HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= NCS_HTRANS_IDLE;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb

    // Device access relayed by the controller; busy is polled, never a fixed wait
    task automatic dev(input logic [9:0] off, input logic w, input logic [31:0] d);
        ahb(NCS_AHB_WDATA, 1'b1, d);
        ahb(NCS_AHB_CMD, 1'b1, (32'h1 << NCS_CMD_GO) | (32'(w) << NCS_CMD_WR) | 32'(off));
        rd = 32'h1;
        // Ends when busy reads 0; if it never does, only the hang guard ends it
        while (rd[NCS_ST_BUSY] !== 1'b0) ahb(NCS_AHB_STATUS, 1'b0, 32'h0);
        if (!w) ahb(NCS_AHB_RDATA, 1'b0, 32'h0);
    endtask : dev

    // Looks for an init pulse over n cycles
    task automatic see_init(input int n, input logic exp);
        logic got;
        got = 1'b0;
        repeat (n) begin
            @(posedge hclk);
            if (phase_init === 1'b1) got = 1'b1;
        end
        chk(32'(got), 32'(exp));
    endtask : see_init

    // Phase advance over n idle cycles
    task automatic step(input int n, input logic [31:0] exp);
        p0 = phase_a;
        repeat (n) @(posedge hclk);
        chk(phase_a - p0, exp);
    endtask : step

    // Sync rise, then a boundary a few cycles later
    task automatic link_start();
        ncs_if_i.sync_n <= 1'b0;
        @(posedge hclk);
        ncs_if_i.sync_n <= 1'b1;
        repeat (4) @(posedge hclk);
        ncs_if_i.frame_boundary <= 1'b1;
        @(posedge hclk);
        ncs_if_i.frame_boundary <= 1'b0;
    endtask : link_start

    task automatic sysref_pulse();
        ncs_if_i.sysref <= 1'b1;
        @(posedge hclk);
        ncs_if_i.sysref <= 1'b0;
    endtask : sysref_pulse

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = NCS_HTRANS_IDLE;
        hwrite = 1'b0;
        hwdata = 32'h0;
        ncs_if_i.sync_n = 1'b1;
        ncs_if_i.frame_boundary = 1'b0;
        ncs_if_i.sysref = 1'b0;
        mismatches = 0;
        cmp_count = 0;
        cyc = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        // Register rows
        foreach (rows[i]) begin
            dev(rows[i].off, 1'b1, rows[i].d);
            dev(rows[i].off, 1'b0, 32'h0);
            chk(rd & rows[i].m, rows[i].d & rows[i].m);
        end
        // Reset in mid-run restores the five values listed in rst
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (rst[i]) begin
            dev(rst[i].off, 1'b0, 32'h0);
            chk(rd & rst[i].m, rst[i].d);
        end
        // A 1 without a prior 0 must not arm
        dev(NCS_OFS_SYNC, 1'b1, 32'h3);
        chk(32'(armed), 32'h0);
        // Divisor warning just above and at the advised limit
        dev(NCS_OFS_RDIV, 1'b1, 32'h2001);
        ahb(NCS_AHB_STATUS, 1'b0, 32'h0);
        chk(32'(rd[NCS_ST_WARN]), 32'h1);
        dev(NCS_OFS_RDIV, 1'b1, 32'(NCS_RDIV_ADVISED_MAX));
        ahb(NCS_AHB_STATUS, 1'b0, 32'h0);
        chk(32'(rd[NCS_ST_WARN]), 32'h0);
        ahb(8'h10, 1'b0, 32'h0);
        chk(rd, 32'h0);
        chk(32'(hresp), 32'h0);
        // Plain accumulator, then a negative word, then divisor 3 (two adds in six cycles)
        dev(NCS_OFS_RDIV, 1'b1, 32'h0);
        dev(NCS_OFS_FREQ_BASE, 1'b1, 32'h01000000);
        step(5, 32'h05000000);
        dev(NCS_OFS_FREQ_BASE, 1'b1, 32'hF0000000);
        step(4, 32'hC0000000);
        dev(NCS_OFS_RDIV, 1'b1, 32'h3);
        step(6, 32'hE0000000);
        dev(NCS_OFS_RDIV, 1'b1, 32'h0);
        // Select preset 1
        dev(10'h228, 1'b1, 32'h00000010);
        dev(NCS_OFS_CSEL, 1'b1, 32'h1);
        step(4, 32'h00000040);
        // Mode with bits [1:0] other than 0 falls back to preset 0 (four adds of F0000000)
        dev(NCS_OFS_PRESET_SELECT_MODE, 1'b1, 32'h1);
        step(4, 32'hC0000000);
        dev(NCS_OFS_PRESET_SELECT_MODE, 1'b1, 32'h0);
        dev(NCS_OFS_CSEL, 1'b1, 32'h0);
        // Channel B runs its reset word, three adds of C0000000
        p0 = phase_b;
        repeat (3) @(posedge hclk);
        chk(phase_b - p0, 32'h40000000);
        // Zero word holds channel A still; the phase word lands in the top half
        dev(NCS_OFS_FREQ_BASE, 1'b1, 32'h0);
        p0 = phase_a;
        dev(NCS_OFS_PHASE_BASE, 1'b1, 32'h00004000);
        chk(phase_a - p0, 32'h40000000);
        // Link start with the bit set, then cleared
        link_start();
        see_init(4, 1'b1);
        dev(NCS_OFS_SYNC, 1'b1, 32'h0);
        link_start();
        see_init(4, 1'b0);
        // Arm, one sysref init, later edges ignored, rearm needs a 0 first
        dev(NCS_OFS_SYNC, 1'b1, 32'h1);
        chk(32'(armed), 32'h1);
        sysref_pulse();
        see_init(5, 1'b1);
        chk(32'(armed), 32'h0);
        sysref_pulse();
        see_init(6, 1'b0);
        dev(NCS_OFS_SYNC, 1'b1, 32'h1);
        chk(32'(armed), 32'h0);
        stop_test();
    end
endmodule : nco_frequency_sync_control_bench
